// ### rtl/ipb_priority_bank.sv
`timescale 1ns/100ps
// Functional notes
// R01 - code 111 is level 7, highest
// R02 - code 000 disables the source
// R03 - codes 001..110 are levels 1..6
// R04 - unimplemented bits ignore writes, read zero
// R05 - every field resets to 100
// R06 - reg4: change notify 14-12, 11-7 unused
// R07 - reg4: i2c1 master 6-4, slave 2-0
// R08 - reg5: cap8, cap7, adc2, ext irq1
// R09 - reg6: timer4, compare4, compare3, dma2
// R10 - reg7: uart2 tx, rx, ext irq2, timer5
// R11 - reg8: can1 event, receive, spi2 event, error
// R12 - fields hold value, drive arbitration continuously
module ipb_priority_bank (
    input  wire logic                  clk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic [3:0]            addr_i,
    input  wire logic [15:0]           wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic      [15:0]           rdata_o,
    output ipb_pkg::ipb_src_prio_t [ipb_pkg::NUM_SRC-1:0] src_prio_o
);

    // one bundled request so every block samples the same bus
    ipb_pkg::ipb_bus_req_t req;

    // per-register write enables, decoded once
    logic        wr4;
    logic        wr5;
    logic        wr6;
    logic        wr7;
    logic        wr8;

    // register words as software sees them
    logic [15:0] prio4_w;
    logic [15:0] prio5_w;
    logic [15:0] prio6_w;
    logic [15:0] prio7_w;
    logic [15:0] prio8_w;

    // read path
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    // one 3-bit code per source; unused bits get no storage at all
    logic [2:0]  change_notify_priority_q;
    logic [2:0]  i2c1_master_priority_q;
    logic [2:0]  i2c1_slave_priority_q;
    logic [2:0]  capture8_priority_q;
    logic [2:0]  capture7_priority_q;
    logic [2:0]  adc2_done_priority_q;
    logic [2:0]  ext_irq1_priority_q;
    logic [2:0]  timer4_priority_q;
    logic [2:0]  compare4_priority_q;
    logic [2:0]  compare3_priority_q;
    logic [2:0]  dma_ch2_done_priority_q;
    logic [2:0]  uart2_transmit_priority_q;
    logic [2:0]  uart2_receive_priority_q;
    logic [2:0]  ext_irq2_priority_q;
    logic [2:0]  timer5_priority_q;
    logic [2:0]  can1_event_priority_q;
    logic [2:0]  can1_receive_priority_q;
    logic [2:0]  spi2_event_priority_q;
    logic [2:0]  spi2_error_priority_q;

    // address decode shared by the write and read paths
    function automatic logic hit(
        input logic [3:0] a,
        input logic [3:0] idx
    );
        return (a == idx);
    endfunction

    // raw code to arbitration view: zero masks the source
    function automatic ipb_pkg::ipb_src_prio_t to_src(
        input logic [2:0] code
    );
        ipb_pkg::ipb_src_prio_t s;
        // R02 zero disables
        s.active = (code != ipb_pkg::PRIO_OFF);
        // R01 R03 linear level
        s.level  = code;
        return s;
    endfunction

    function automatic logic [2:0] fld(
        input logic [15:0] r,
        input int          lsb
    );
        return r[lsb +: 3];
    endfunction

    // four fields into one word; gaps stay zero
    function automatic logic [15:0] pack(
        input logic [2:0] hi,
        input logic [2:0] mh,
        input logic [2:0] ml,
        input logic [2:0] lo
    );
        logic [15:0] w;
        w = 16'h0000;
        w[ipb_pkg::FLD_HI_LSB +: 3] = hi;
        w[ipb_pkg::FLD_MH_LSB +: 3] = mh;
        w[ipb_pkg::FLD_ML_LSB +: 3] = ml;
        w[ipb_pkg::FLD_LO_LSB +: 3] = lo;
        return w;
    endfunction

    assign req = {wr_i, rd_i, addr_i, wdata_i};

    assign wr4 = req.wr && hit(req.addr, ipb_pkg::PRIO_CTRL_4_IDX);
    assign wr5 = req.wr && hit(req.addr, ipb_pkg::PRIO_CTRL_5_IDX);
    assign wr6 = req.wr && hit(req.addr, ipb_pkg::PRIO_CTRL_6_IDX);
    assign wr7 = req.wr && hit(req.addr, ipb_pkg::PRIO_CTRL_7_IDX);
    assign wr8 = req.wr && hit(req.addr, ipb_pkg::PRIO_CTRL_8_IDX);

    // R05 R12 reset to level 4, else hold
    // R06 change notify
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            change_notify_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr4) begin
            change_notify_priority_q <= fld(req.wdata, ipb_pkg::FLD_HI_LSB);
        end
    end

    // R07 i2c1 master, slave
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            i2c1_master_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr4) begin
            i2c1_master_priority_q <= fld(req.wdata, ipb_pkg::FLD_ML_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            i2c1_slave_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr4) begin
            i2c1_slave_priority_q <= fld(req.wdata, ipb_pkg::FLD_LO_LSB);
        end
    end

    // R08 capture8, capture7, adc2, ext irq1
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            capture8_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr5) begin
            capture8_priority_q <= fld(req.wdata, ipb_pkg::FLD_HI_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            capture7_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr5) begin
            capture7_priority_q <= fld(req.wdata, ipb_pkg::FLD_MH_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            adc2_done_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr5) begin
            adc2_done_priority_q <= fld(req.wdata, ipb_pkg::FLD_ML_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ext_irq1_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr5) begin
            ext_irq1_priority_q <= fld(req.wdata, ipb_pkg::FLD_LO_LSB);
        end
    end

    // R09 timer4, compare4, compare3, dma2
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            timer4_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr6) begin
            timer4_priority_q <= fld(req.wdata, ipb_pkg::FLD_HI_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            compare4_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr6) begin
            compare4_priority_q <= fld(req.wdata, ipb_pkg::FLD_MH_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            compare3_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr6) begin
            compare3_priority_q <= fld(req.wdata, ipb_pkg::FLD_ML_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dma_ch2_done_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr6) begin
            dma_ch2_done_priority_q <= fld(req.wdata, ipb_pkg::FLD_LO_LSB);
        end
    end

    // R10 uart2 tx, rx, ext irq2, timer5
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            uart2_transmit_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr7) begin
            uart2_transmit_priority_q <= fld(req.wdata, ipb_pkg::FLD_HI_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            uart2_receive_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr7) begin
            uart2_receive_priority_q <= fld(req.wdata, ipb_pkg::FLD_MH_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ext_irq2_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr7) begin
            ext_irq2_priority_q <= fld(req.wdata, ipb_pkg::FLD_ML_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            timer5_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr7) begin
            timer5_priority_q <= fld(req.wdata, ipb_pkg::FLD_LO_LSB);
        end
    end

    // R11 can1 event, receive, spi2 event, error
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            can1_event_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr8) begin
            can1_event_priority_q <= fld(req.wdata, ipb_pkg::FLD_HI_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            can1_receive_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr8) begin
            can1_receive_priority_q <= fld(req.wdata, ipb_pkg::FLD_MH_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            spi2_event_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr8) begin
            spi2_event_priority_q <= fld(req.wdata, ipb_pkg::FLD_ML_LSB);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            spi2_error_priority_q <= ipb_pkg::PRIO_RESET;
        end else if (wr8) begin
            spi2_error_priority_q <= fld(req.wdata, ipb_pkg::FLD_LO_LSB);
        end
    end

    // R04 unused bits read zero; reg4 has no middle field
    assign prio4_w = pack(change_notify_priority_q, ipb_pkg::PRIO_OFF,
                          i2c1_master_priority_q, i2c1_slave_priority_q)
                     & ipb_pkg::MASK_REG4;
    assign prio5_w = pack(capture8_priority_q, capture7_priority_q,
                          adc2_done_priority_q, ext_irq1_priority_q);
    assign prio6_w = pack(timer4_priority_q, compare4_priority_q,
                          compare3_priority_q, dma_ch2_done_priority_q);
    assign prio7_w = pack(uart2_transmit_priority_q, uart2_receive_priority_q,
                          ext_irq2_priority_q, timer5_priority_q);
    assign prio8_w = pack(can1_event_priority_q, can1_receive_priority_q,
                          spi2_event_priority_q, spi2_error_priority_q);

    // unmapped addresses read zero
    always_comb begin
        rdata_d = 16'h0000;
        if (hit(req.addr, ipb_pkg::PRIO_CTRL_4_IDX)) begin
            rdata_d = prio4_w;
        end else if (hit(req.addr, ipb_pkg::PRIO_CTRL_5_IDX)) begin
            rdata_d = prio5_w;
        end else if (hit(req.addr, ipb_pkg::PRIO_CTRL_6_IDX)) begin
            rdata_d = prio6_w;
        end else if (hit(req.addr, ipb_pkg::PRIO_CTRL_7_IDX)) begin
            rdata_d = prio7_w;
        end else if (hit(req.addr, ipb_pkg::PRIO_CTRL_8_IDX)) begin
            rdata_d = prio8_w;
        end
    end

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= 16'h0000;
        end else if (req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign rdata_o = rdata_q;

    // R01 R02 R03 code to arbitration view
    // R06 change notify
    assign src_prio_o[0]  = to_src(change_notify_priority_q);
    // R07 i2c1 master, slave
    assign src_prio_o[1]  = to_src(i2c1_master_priority_q);
    assign src_prio_o[2]  = to_src(i2c1_slave_priority_q);
    // R08 capture8, capture7, adc2, ext irq1
    assign src_prio_o[3]  = to_src(capture8_priority_q);
    assign src_prio_o[4]  = to_src(capture7_priority_q);
    assign src_prio_o[5]  = to_src(adc2_done_priority_q);
    assign src_prio_o[6]  = to_src(ext_irq1_priority_q);
    // R09 timer4, compare4, compare3, dma2
    assign src_prio_o[7]  = to_src(timer4_priority_q);
    assign src_prio_o[8]  = to_src(compare4_priority_q);
    assign src_prio_o[9]  = to_src(compare3_priority_q);
    assign src_prio_o[10] = to_src(dma_ch2_done_priority_q);
    // R10 uart2 tx, rx, ext irq2, timer5
    assign src_prio_o[11] = to_src(uart2_transmit_priority_q);
    assign src_prio_o[12] = to_src(uart2_receive_priority_q);
    assign src_prio_o[13] = to_src(ext_irq2_priority_q);
    assign src_prio_o[14] = to_src(timer5_priority_q);
    // R11 can1 event, receive, spi2 event, error
    assign src_prio_o[15] = to_src(can1_event_priority_q);
    assign src_prio_o[16] = to_src(can1_receive_priority_q);
    assign src_prio_o[17] = to_src(spi2_event_priority_q);
    assign src_prio_o[18] = to_src(spi2_error_priority_q);

endmodule // ipb_priority_bank

// ### rtl/ipb_pkg.sv
package ipb_pkg;

    // register indices (word addresses on the plain port)
    localparam logic [3:0] PRIO_CTRL_4_IDX = 4'h4;
    localparam logic [3:0] PRIO_CTRL_5_IDX = 4'h5;
    localparam logic [3:0] PRIO_CTRL_6_IDX = 4'h6;
    localparam logic [3:0] PRIO_CTRL_7_IDX = 4'h7;
    localparam logic [3:0] PRIO_CTRL_8_IDX = 4'h8;

    // field positions (low bit of each 3-bit field)
    localparam int FLD_HI_LSB  = 12;
    localparam int FLD_MH_LSB  = 8;
    localparam int FLD_ML_LSB  = 4;
    localparam int FLD_LO_LSB  = 0;

    // writable bit masks
    localparam logic [15:0] MASK_FULL  = 16'h7777;
    localparam logic [15:0] MASK_REG4  = 16'h7077;

    // value after reset: level 4 in every field
    localparam logic [2:0]  PRIO_RESET = 3'h4;
    localparam logic [15:0] RST_FULL   = 16'h4444;
    localparam logic [15:0] RST_REG4   = 16'h4044;

    localparam logic [2:0]  PRIO_OFF   = 3'h0;
    localparam logic [2:0]  PRIO_TOP   = 3'h7;
    localparam int          NUM_SRC    = 19;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } ipb_bus_req_t;

    // per-source view for arbitration
    typedef struct packed {
        logic       active;
        logic [2:0] level;
    } ipb_src_prio_t;

endpackage

// ### test/ipb_priority_bank_assertions.sv
`timescale 1ns/100ps
module ipb_chk (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    input wire ipb_pkg::ipb_src_prio_t [ipb_pkg::NUM_SRC-1:0] src_prio_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_fld(logic [3:0] a, int s, int b);
        wr_i && addr_i == a |=> src_prio_o[s].level == $past(wdata_i[b+:3]);
    endproperty
    a_gap_zero: assert property (!(rdata_o & 16'h8888)) else $error("gap");
    a_rst_lvl: assert property ($past(sys_rst_i) |-> src_prio_o[5] == 4'hc)
        else $error("rst");
    a_off_src: assert property (src_prio_o[9].active == |src_prio_o[9].level)
        else $error("off");
    a_hold_value: assert property (!wr_i |=> $stable(src_prio_o))
        else $error("hold");
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("idle");
    a_cn_fld: assert property (p_fld(4'h4, 0, 12)) else $error("cn");
    a_i2c_fld: assert property (p_fld(4'h4, 2, 0)) else $error("i2c");
    a_cap_fld: assert property (p_fld(4'h5, 4, 8)) else $error("cap");
    a_spi_fld: assert property (p_fld(4'h8, 17, 4)) else $error("spi");
    c_unmapped: cover property (wr_i && addr_i == 4'h9);
    c_top_lvl: cover property (src_prio_o[2].level == 3'h7);
    c_src_off: cover property (!src_prio_o[7].active);
endmodule // ipb_chk
bind ipb_priority_bank ipb_chk chk_u (.clk_i, .sys_rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .src_prio_o);

// ### test/interrupt_priority_bank_tb.sv
`timescale 1ns/100ps
module interrupt_priority_bank_tb;
    logic        clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0, rdata_o;
    ipb_pkg::ipb_src_prio_t [ipb_pkg::NUM_SRC-1:0] src_prio_o;
    int          fails = 0, n_compared = 0;
    ipb_priority_bank dut_u (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .src_prio_o);
    initial forever #50 clk_i = ~clk_i;
    task automatic chk(input logic [75:0] got, exp);
        n_compared++;
        fails += int'(got !== exp);
        if (got !== exp) $display("Error %0t: %h vs %h", $time, got, exp);
    endtask
    // reads carry the expected word in d
    task automatic bus(input logic w, logic [3:0] a, logic [15:0] d);
        @(posedge clk_i);
        {wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, d};
        @(posedge clk_i);
        {wr_i, rd_i} <= 2'h0;
        #1 if (!w) chk(76'(rdata_o), 76'(d));
        @(posedge clk_i);
        #1 if (!w) chk(76'(rdata_o), 76'h0);
    endtask
    task automatic t_reset;
        repeat (6) @(posedge clk_i) sys_rst_i <= 1'h1;
        @(posedge clk_i) sys_rst_i <= 1'h0;
        for (int r = 4; r < 9; r++)
            bus(1'h0, 4'(r), r == 4 ? 16'h4044 : 16'h4444);
        chk(src_prio_o, 76'hccc_cccc_cccc_cccc_cccc);
        $display("reset values checked");
    endtask
    task automatic t_fields;
        for (int r = 3; r < 10; r++) bus(1'h1, 4'(r), 16'hffff);
        for (int r = 3; r < 10; r++)
            bus(1'h0, 4'(r), r == 4 ? 16'h7077 : r % 9 > 3 ? 16'h7777 : 16'h0);
        for (int r = 4; r < 9; r++) bus(1'h1, 4'(r), 16'h1357);
        chk(src_prio_o, 76'hfdb9_fdb9_fdb9_fdb9_fd9);
        bus(1'h1, 4'h6, 16'h0);
        chk(src_prio_o, 76'hfdb9_fdb9_0000_fdb9_fd9);
        bus(1'h0, 4'h5, 16'h1357);
        $display("field map checked");
    endtask
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        t_reset();
        t_fields();
        t_reset();
        complete_run();
    end
endmodule // interrupt_priority_bank_tb
